//--- hdl/timer_defs.svh
// Functional notes
// RQ1: 8-bit timer behind 8-bit prescaler, shared addresses
// RQ2: secondary reload kept but unused in timer mode
// RQ3: mode field bits 5:4, 00 is timer
// RQ4: source undivided, div2, div8 or companion underflow
// RQ5: decrement, reload from primary, keep counting
// RQ6: underflow every (n+1)(m+1) source cycles
// RQ7: start flag 1 counts, 0 stops
// RQ8: underflow raises timer interrupt request
// RQ9: timer mode leaves waveform pin as port
// RQ10: period and prescaler reads return live counts
// RQ11: stopped write loads reload and counter
// RQ12: running write-control 0: latch, copy, resume
// RQ13: write-control 1 writes reload only, next reload
// RQ14: write-control 0 running write sets request flag
// RQ15: software writes zero to output control bits 4:0
// RQ16: prescaler per tick, timer per prescaler underflow
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH
`define OFF_MODE      8'h80
`define OFF_WAVE_CTL  8'h84
`define OFF_PERIOD    8'h88
`define OFF_PRESCALE  8'h8C
`define OFF_SECONDARY 8'h90
`define OFF_SRCSEL    8'h94
`define OFF_STATUS    8'h98
`define OFF_MASK      8'h9C
`define MODE_LSB      4
`define WC_BIT        6
`define START_BIT     7
`define MODE_WMASK    8'hF0
`define WAVE_WMASK    8'hE0
`define RST_BYTE      8'h00
`define DIV8_LAST     3'h7
`endif

//--- hdl/timer_pkg.sv
package timer_pkg;
	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_LATCH  = 4'b0010,
		ST_COPY   = 4'b0100,
		ST_RESUME = 4'b1000
	} wstate_t;
	typedef enum logic [1:0] {
		SRC_UNDIV  = 2'b00,
		SRC_DIV2   = 2'b01,
		SRC_DIV8   = 2'b10,
		SRC_COMPAN = 2'b11
	} src_t;
	typedef enum logic [1:0] {
		MODE_TIMER = 2'b00,
		MODE_WAVE  = 2'b01,
		MODE_OS    = 2'b10,
		MODE_WOS   = 2'b11
	} mode_t;
	typedef struct packed {
		logic [7:0]  mode_reg;
		logic [7:0]  wave_ctl_reg;
		logic [7:0]  sec_reg;
		logic [7:0]  pres_rel;
		logic [7:0]  pres_cnt;
		logic [7:0]  tmr_rel;
		logic [7:0]  tmr_cnt;
		logic [7:0]  staged_per;
		logic [7:0]  staged_pres;
		logic        pend_per;
		logic        pend_pres;
		src_t        src_sel;
		logic        stat;
		logic        mask;
		logic [2:0]  div_cnt;
		wstate_t     wstate;
		logic        dp_wr;
		logic        dp_rd;
		logic [7:0]  dp_addr;
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
		logic        irq;
		logic        pin;
	} state_t;
endpackage : timer_pkg

//--- hdl/prescaled_reload_timer.sv
`timescale 1ns/1ps
`include "timer_defs.svh"
module prescaled_reload_timer (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [1:0]  htrans,
	input  wire logic [31:0] haddr,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	input  wire logic        companion_underflow,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             irq,
	output logic             waveform_output_pin
);
	import timer_pkg::*;

	state_t r_reg;
	state_t r_next;
	logic   tick;
	logic   uf;
	logic   run_ok;
	logic   wr_now;

	function automatic logic [7:0] read_mux(input state_t s, input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			`OFF_MODE:      v = s.mode_reg;
			`OFF_WAVE_CTL:  v = s.wave_ctl_reg;
			`OFF_PERIOD:    v = s.tmr_cnt; // RQ10
			`OFF_PRESCALE:  v = s.pres_cnt; // RQ10
			`OFF_SECONDARY: v = s.sec_reg;
			`OFF_SRCSEL:    v = {6'h00, s.src_sel};
			`OFF_STATUS:    v = {7'h00, s.stat};
			`OFF_MASK:      v = {7'h00, s.mask};
			default:        v = 8'h00;
		endcase
		return v;
	endfunction : read_mux

	always_comb begin
		r_next = r_reg;
		wr_now = r_reg.dp_wr;
		// free-running divider gives the internal prescaled sources
		r_next.div_cnt = r_reg.div_cnt + 3'h1;
		case (r_reg.src_sel) // RQ4
			SRC_UNDIV:  tick = 1'b1;
			SRC_DIV2:   tick = r_reg.div_cnt[0];
			SRC_DIV8:   tick = (r_reg.div_cnt == `DIV8_LAST);
			SRC_COMPAN: tick = companion_underflow;
			default:    tick = 1'b0;
		endcase
		run_ok = r_reg.mode_reg[`START_BIT] &&
			(r_reg.wstate == ST_IDLE || r_reg.wstate == ST_RESUME); // RQ7
		uf = 1'b0;

		// counting chain; only timer mode exists, other codes behave the same
		if (tick && run_ok) begin
			if (r_reg.pres_cnt == 8'h00) begin
				r_next.pres_cnt = r_reg.pres_rel; // RQ16
				if (r_reg.tmr_cnt == 8'h00) begin
					r_next.tmr_cnt = r_reg.tmr_rel; // RQ5 RQ6
					uf = 1'b1;
				end else begin
					r_next.tmr_cnt = r_reg.tmr_cnt - 8'h01; // RQ16
				end
			end else begin
				r_next.pres_cnt = r_reg.pres_cnt - 8'h01; // RQ16
			end
		end

		// staged write sequence of a running write with write-control 0
		case (r_reg.wstate)
			ST_IDLE: begin
			end
			ST_LATCH: begin
				if (tick) begin
					if (r_reg.pend_per)
						r_next.tmr_rel = r_reg.staged_per; // RQ12
					if (r_reg.pend_pres)
						r_next.pres_rel = r_reg.staged_pres; // RQ12
					r_next.wstate = ST_COPY;
				end
			end
			ST_COPY: begin
				if (tick) begin
					if (r_reg.pend_per)
						r_next.tmr_cnt = r_reg.tmr_rel; // RQ12
					if (r_reg.pend_pres)
						r_next.pres_cnt = r_reg.pres_rel; // RQ12
					r_next.wstate = ST_RESUME;
				end
			end
			ST_RESUME: begin
				if (tick) begin
					r_next.wstate = ST_IDLE; // RQ12
					r_next.pend_per = 1'b0;
					r_next.pend_pres = 1'b0;
				end
			end
			default: r_next.wstate = ST_IDLE;
		endcase

		// interrupt status; a new event beats a same-cycle clear
		if (wr_now && r_reg.dp_addr == `OFF_STATUS && hwdata[0])
			r_next.stat = 1'b0;

		// register writes (data phase)
		if (wr_now) begin
			case (r_reg.dp_addr)
				`OFF_MODE: begin
					r_next.mode_reg = hwdata[7:0] & `MODE_WMASK; // RQ3
					if (!hwdata[`START_BIT]) begin
						r_next.wstate = ST_IDLE;
						r_next.pend_per = 1'b0;
						r_next.pend_pres = 1'b0;
					end
				end
				// low bits are reserved; the write mask stores them as zero
				`OFF_WAVE_CTL:  r_next.wave_ctl_reg = hwdata[7:0] & `WAVE_WMASK; // RQ15
				`OFF_SECONDARY: r_next.sec_reg = hwdata[7:0]; // RQ2
				`OFF_SRCSEL:    r_next.src_sel = src_t'(hwdata[1:0]);
				`OFF_MASK:      r_next.mask = hwdata[0];
				`OFF_PERIOD, `OFF_PRESCALE: begin // RQ1
					if (!r_reg.mode_reg[`START_BIT]) begin
						if (r_reg.dp_addr == `OFF_PERIOD) begin
							r_next.tmr_rel = hwdata[7:0]; // RQ11
							r_next.tmr_cnt = hwdata[7:0]; // RQ11
						end else begin
							r_next.pres_rel = hwdata[7:0]; // RQ11
							r_next.pres_cnt = hwdata[7:0]; // RQ11
						end
					end else if (r_reg.mode_reg[`WC_BIT]) begin
						if (r_reg.dp_addr == `OFF_PERIOD)
							r_next.tmr_rel = hwdata[7:0]; // RQ13
						else
							r_next.pres_rel = hwdata[7:0]; // RQ13
					end else begin
						if (r_reg.dp_addr == `OFF_PERIOD) begin
							r_next.staged_per = hwdata[7:0]; // RQ12
							r_next.pend_per = 1'b1;
						end else begin
							r_next.staged_pres = hwdata[7:0]; // RQ12
							r_next.pend_pres = 1'b1;
						end
						r_next.wstate = ST_LATCH; // RQ12
						r_next.stat = 1'b1; // RQ14
					end
				end
				default: begin
				end
			endcase
		end

		if (uf)
			r_next.stat = 1'b1; // RQ8

		// bus: writes finish with no wait, reads take one wait state
		r_next.dp_wr = 1'b0;
		r_next.dp_rd = 1'b0;
		r_next.hreadyout = 1'b1;
		// no access can fail, so the response is always okay
		r_next.hresp = 1'b0;
		if (r_reg.dp_rd) begin
			r_next.hrdata = {24'h00_0000, read_mux(r_reg, r_reg.dp_addr)};
		end else if (hsel && htrans[1] && hready && hsize == 3'b010) begin
			r_next.dp_addr = haddr[7:0];
			r_next.dp_wr = hwrite;
			r_next.dp_rd = !hwrite;
			r_next.hreadyout = hwrite;
		end

		r_next.irq = r_next.stat && r_next.mask;
		// in timer mode the pin belongs to the port logic; idles low
		r_next.pin = 1'b0; // RQ9
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_reg <= '{
				mode_reg: `RST_BYTE, wave_ctl_reg: `RST_BYTE, sec_reg: `RST_BYTE,
				pres_rel: `RST_BYTE, pres_cnt: `RST_BYTE, tmr_rel: `RST_BYTE,
				tmr_cnt: `RST_BYTE, staged_per: `RST_BYTE, staged_pres: `RST_BYTE,
				pend_per: 1'b0, pend_pres: 1'b0, src_sel: SRC_UNDIV, stat: 1'b0,
				mask: 1'b0, div_cnt: 3'h0, wstate: ST_IDLE, dp_wr: 1'b0,
				dp_rd: 1'b0, dp_addr: 8'h00, hrdata: 32'h0000_0000,
				hreadyout: 1'b1, hresp: 1'b0, irq: 1'b0, pin: 1'b0};
		end else begin
			r_reg <= r_next;
		end
	end

	assign hrdata = r_reg.hrdata;
	assign hreadyout = r_reg.hreadyout;
	assign hresp = r_reg.hresp;
	assign irq = r_reg.irq;
	assign waveform_output_pin = r_reg.pin;

	property p_underflow_reload;
		@(posedge hclk) disable iff (!hresetn)
		uf && !wr_now |=> r_reg.tmr_cnt == $past(r_reg.tmr_rel);
	endproperty
	a_underflow_reload: assert property (p_underflow_reload) // RQ5
		else $error("timer did not reload from primary on underflow");

	property p_irq_on_underflow;
		@(posedge hclk) disable iff (!hresetn)
		uf |=> r_reg.stat && (r_reg.irq == r_reg.mask);
	endproperty
	a_irq_on_underflow: assert property (p_irq_on_underflow) // RQ8
		else $error("underflow did not raise the request");

	property p_stop_holds;
		@(posedge hclk) disable iff (!hresetn)
		!r_reg.mode_reg[`START_BIT] && !wr_now |=>
			$stable(r_reg.tmr_cnt) && $stable(r_reg.pres_cnt);
	endproperty
	a_stop_holds: assert property (p_stop_holds) // RQ7
		else $error("counters moved while stopped");

	property p_stopped_write;
		@(posedge hclk) disable iff (!hresetn)
		wr_now && r_reg.dp_addr == `OFF_PERIOD && !r_reg.mode_reg[`START_BIT] |=>
			r_reg.tmr_cnt == $past(hwdata[7:0]) && r_reg.tmr_rel == $past(hwdata[7:0]);
	endproperty
	a_stopped_write: assert property (p_stopped_write) // RQ11
		else $error("stopped write did not load reload and counter");

	property p_wc1_reload_only;
		@(posedge hclk) disable iff (!hresetn)
		wr_now && r_reg.dp_addr == `OFF_PERIOD && r_reg.mode_reg[`START_BIT] &&
			r_reg.mode_reg[`WC_BIT] && r_reg.wstate == ST_IDLE && !tick |=>
			r_reg.tmr_rel == $past(hwdata[7:0]) && $stable(r_reg.tmr_cnt);
	endproperty
	a_wc1_reload_only: assert property (p_wc1_reload_only) // RQ13
		else $error("write-control 1 write missed the reload register");

	property p_wc0_sequence;
		@(posedge hclk) disable iff (!hresetn)
		wr_now && r_reg.dp_addr == `OFF_PERIOD && r_reg.mode_reg[`START_BIT] &&
			!r_reg.mode_reg[`WC_BIT] |=> r_reg.stat && r_reg.wstate == ST_LATCH;
	endproperty
	a_wc0_sequence: assert property (p_wc0_sequence) // RQ14
		else $error("running write-control 0 write did not stage or flag");

	property p_prescale_step;
		@(posedge hclk) disable iff (!hresetn)
		tick && run_ok && r_reg.pres_cnt != 8'h00 && !wr_now |=>
			r_reg.pres_cnt == $past(r_reg.pres_cnt) - 8'h01;
	endproperty
	a_prescale_step: assert property (p_prescale_step) // RQ16
		else $error("prescaler did not step on count source");

	property p_pin_port;
		@(posedge hclk) disable iff (!hresetn)
		r_reg.mode_reg[5:4] == MODE_TIMER |=> !waveform_output_pin;
	endproperty
	a_pin_port: assert property (p_pin_port) // RQ9
		else $error("timer mode drove the waveform pin");

	property p_read_wait;
		@(posedge hclk) disable iff (!hresetn)
		hsel && htrans[1] && hready && !hwrite && hsize == 3'b010 && !r_reg.dp_rd
			|=> !hreadyout ##1 hreadyout;
	endproperty
	a_read_wait: assert property (p_read_wait)
		else $error("read did not take exactly one wait state");

	property p_latch_reload;
		@(posedge hclk) disable iff (!hresetn)
		r_reg.wstate == ST_LATCH && tick && r_reg.pend_per && !wr_now |=>
			r_reg.tmr_rel == $past(r_reg.staged_per) && r_reg.wstate == ST_COPY;
	endproperty
	a_latch_reload: assert property (p_latch_reload) // RQ12
		else $error("staged period did not reach the reload register");

	property p_copy_counter;
		@(posedge hclk) disable iff (!hresetn)
		r_reg.wstate == ST_COPY && tick && r_reg.pend_per && !wr_now |=>
			r_reg.tmr_cnt == $past(r_reg.tmr_rel) && r_reg.wstate == ST_RESUME;
	endproperty
	a_copy_counter: assert property (p_copy_counter) // RQ12
		else $error("reload was not copied to the counter");

	// the staged sequence must not let the counters run early
	property p_staged_hold;
		@(posedge hclk) disable iff (!hresetn)
		r_reg.wstate == ST_LATCH && !wr_now |=>
			$stable(r_reg.tmr_cnt) && $stable(r_reg.pres_cnt);
	endproperty
	a_staged_hold: assert property (p_staged_hold) // RQ12
		else $error("counters moved before the staged copy");

	property p_resume_idle;
		@(posedge hclk) disable iff (!hresetn)
		r_reg.wstate == ST_RESUME && tick && !wr_now |=>
			r_reg.wstate == ST_IDLE && !r_reg.pend_per;
	endproperty
	a_resume_idle: assert property (p_resume_idle) // RQ12
		else $error("staged sequence did not finish on the third tick");

	property p_status_clear;
		@(posedge hclk) disable iff (!hresetn)
		wr_now && r_reg.dp_addr == `OFF_STATUS && hwdata[0] && !uf |=>
			!r_reg.stat;
	endproperty
	a_status_clear: assert property (p_status_clear) // RQ8
		else $error("writing one did not clear the request");

	property p_stop_cancels;
		@(posedge hclk) disable iff (!hresetn)
		wr_now && r_reg.dp_addr == `OFF_MODE && !hwdata[`START_BIT] |=>
			r_reg.wstate == ST_IDLE && !r_reg.pend_per && !r_reg.pend_pres;
	endproperty
	a_stop_cancels: assert property (p_stop_cancels) // RQ7
		else $error("stop did not cancel a staged write");

	property p_write_no_wait;
		@(posedge hclk) disable iff (!hresetn)
		hsel && htrans[1] && hready && hwrite && hsize == 3'b010 |=>
			hreadyout;
	endproperty
	a_write_no_wait: assert property (p_write_no_wait)
		else $error("write data phase was stalled");

	property p_read_upper_zero;
		@(posedge hclk) disable iff (!hresetn)
		r_reg.dp_rd |=>
			hrdata[31:8] == 24'h00_0000;
	endproperty
	a_read_upper_zero: assert property (p_read_upper_zero) // RQ1
		else $error("read data wider than one byte");

	property p_period_read;
		@(posedge hclk) disable iff (!hresetn)
		r_reg.dp_rd && r_reg.dp_addr == `OFF_PERIOD |=>
			hrdata[7:0] == $past(r_reg.tmr_cnt);
	endproperty
	a_period_read: assert property (p_period_read) // RQ10
		else $error("period read did not return the live count");
endmodule : prescaled_reload_timer

//--- dv/prescaled_reload_timer_timer_mode_test.sv
`timescale 1ns/1ps
`include "timer_defs.svh"
module prescaled_reload_timer_timer_mode_test;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [1:0]  htrans;
	logic [31:0] haddr;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hready;
	logic        companion_underflow;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        irq;
	logic        waveform_output_pin;
	logic        comp_run;
	logic        comp_one;
	logic [31:0] rdat;
	int          cyc;
	int          t0;
	int          bad_count;
	int          n_checks;
	// one slave only, so its ready is the bus ready
	assign hready = hreadyout;
	prescaled_reload_timer i_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .haddr(haddr),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.companion_underflow(companion_underflow), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .irq(irq),
		.waveform_output_pin(waveform_output_pin)
	);
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	// companion pulses: free-running every 4th cycle, or single ones on demand
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		companion_underflow <= (comp_run && cyc[1:0] == 2'd3) || comp_one;
		if (cyc == 5000) begin
			bad_count++;
			test_done();
		end
	end
	task test_done;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// single word transfer; the master waits as long as the slave stalls
	task bus(input logic [7:0] a, input logic wr, input logic [7:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h00_0000, a};
		hwrite <= wr;
		hsize <= 3'b010;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h00_0000, d};
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		rdat = hrdata;
	endtask : bus
	task wr(input logic [7:0] a, input logic [7:0] d);
		bus(a, 1'b1, d);
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] exp);
		bus(a, 1'b0, 8'h00);
		chk(rdat, {24'h00_0000, exp});
	endtask : rd
	task pulse;
		comp_one <= 1'b1;
		@(posedge hclk);
		comp_one <= 1'b0;
		repeat (3) @(posedge hclk);
	endtask : pulse
	task wait_irq(input logic lvl);
		while (irq !== lvl) @(posedge hclk);
	endtask : wait_irq
	// time between two underflows, cleared in between; n = m = 3
	task measure(input logic [7:0] src);
		int sp;
		sp = (src == 0) ? 1 : (src == 1) ? 2 : (src == 2) ? 8 : 4;
		comp_run <= (src == 8'h03);
		wr(`OFF_SRCSEL, src);
		wr(`OFF_MODE, 8'hC0);
		wait_irq(1'b1);
		wr(`OFF_STATUS, 8'h01);
		wait_irq(1'b0);
		wait_irq(1'b1);
		t0 = cyc;
		wr(`OFF_STATUS, 8'h01);
		wait_irq(1'b0);
		wait_irq(1'b1);
		chk(cyc - t0, 16 * sp);
		wr(`OFF_MODE, 8'h00);
		wr(`OFF_STATUS, 8'h01);
		$display("test period source %0d done", src);
	endtask : measure
	initial begin
		bad_count = 0;
		n_checks = 0;
		comp_run = 1'b0;
		comp_one = 1'b0;
		hsel = 1'b0;
		htrans = 2'b00;
		haddr = 32'h0000_0000;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
		hresetn = 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(`OFF_MODE, 8'h00);
		rd(`OFF_WAVE_CTL, 8'h00);
		rd(`OFF_STATUS, 8'h00);
		rd(8'hA0, 8'h00);
		wr(`OFF_MODE, 8'h3F);
		rd(`OFF_MODE, 8'h30);
		wr(`OFF_WAVE_CTL, 8'hE0);
		rd(`OFF_WAVE_CTL, 8'hE0);
		wr(`OFF_WAVE_CTL, 8'h00);
		wr(`OFF_SECONDARY, 8'h5A);
		rd(`OFF_SECONDARY, 8'h5A);
		wr(`OFF_MODE, 8'h00);
		chk(hresp, 1'b0);
		chk(waveform_output_pin, 1'b0);
		$display("test registers done");
		wr(`OFF_PRESCALE, 8'h03);
		wr(`OFF_PERIOD, 8'h03);
		rd(`OFF_PRESCALE, 8'h03);
		rd(`OFF_PERIOD, 8'h03);
		wr(`OFF_MASK, 8'h01);
		for (int s = 0; s < 4; s++)
			measure(s[7:0]);
		comp_run <= 1'b0;
		// deferred write: reload only, counter picks it up at next underflow
		wr(`OFF_PRESCALE, 8'h00);
		wr(`OFF_PERIOD, 8'h03);
		wr(`OFF_MODE, 8'hC0);
		wr(`OFF_PERIOD, 8'h07);
		rd(`OFF_PERIOD, 8'h03);
		rd(`OFF_STATUS, 8'h00);
		repeat (3) pulse();
		rd(`OFF_PERIOD, 8'h00);
		pulse();
		rd(`OFF_PERIOD, 8'h07);
		rd(`OFF_STATUS, 8'h01);
		chk(irq, 1'b1);
		wr(`OFF_MODE, 8'h00);
		wr(`OFF_STATUS, 8'h01);
		$display("test deferred write done");
		// immediate write while running: latch, copy, then resume
		wr(`OFF_MASK, 8'h00);
		wr(`OFF_PERIOD, 8'hC8);
		wr(`OFF_MODE, 8'h80);
		wr(`OFF_PERIOD, 8'h05);
		rd(`OFF_STATUS, 8'h01);
		chk(irq, 1'b0);
		pulse();
		rd(`OFF_PERIOD, 8'hC8);
		pulse();
		rd(`OFF_PERIOD, 8'h05);
		pulse();
		rd(`OFF_PERIOD, 8'h04);
		wr(`OFF_MASK, 8'h01);
		rd(`OFF_STATUS, 8'h01);
		chk(irq, 1'b1);
		wr(`OFF_STATUS, 8'h01);
		rd(`OFF_STATUS, 8'h00);
		chk(irq, 1'b0);
		wr(`OFF_MODE, 8'h00);
		pulse();
		rd(`OFF_PERIOD, 8'h04);
		$display("test immediate write done");
		test_done();
	end
endmodule : prescaled_reload_timer_timer_mode_test
